// ---- core/phy_rx_pkg.sv ----
// shared constants and types of the 10/100 receive path
// assumes a 250 MHz core clock and a symbol clock sampled from the line side
// Function
// - 10M: carrier sense on first decoder edge
// - no mid-bit edges: drop CRS within 1.5 bits
// - receive clock runs five bits after CRS
// - 10M bits grouped into nibbles for MAC
// - no link pulses: disable transmit, receive, collision
// - 100M link needs locked scrambled idle stream
// - fast link pulses never raise signal detect
// - MLT-3 decoded to NRZI, then NRZ
// - plain bit is received bit XOR sequence
// - lock after twelve consecutive unscrambled idles
// - hold timer restarts after sixteen idles
// - hold expiry drops lock, resets descrambler
// - align code-groups on start pair; bypass allowed
// - start pair replaced by two preamble nibbles
// - packet ends on end delimiter or two idles
// - link up after 500 ms signal detect
// - bad start: error and 1110 until idles
// - two idles release error and carrier
// - half duplex: CRS on transmit or receive
// - full duplex: CRS on receive only
// - half duplex: collision on simultaneous activity
// - 10M: 1 us heartbeat on COL after transmit
// - invalid code-group gives nibble 6h with error
// - control code-groups inside data are errors
// - receive clock 25 MHz or 2.5 MHz
package phy_rx_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int HOLD_MS = 722;
  localparam int HOLD_CYC = HOLD_MS * 1000000 / CLK_NS;
  localparam int LINK_MS = 500;
  localparam int LINK_CYC = LINK_MS * 1000000 / CLK_NS;
  localparam int NLP_LOSS_MS = 150;
  localparam int NLP_CYC = NLP_LOSS_MS * 1000000 / CLK_NS;
  localparam int HB_US = 1;
  localparam int HB_CYC = HB_US * 1000 / CLK_NS;
  localparam int BIT10_NS = 100;
  localparam int BIT10_CYC = BIT10_NS / CLK_NS;
  localparam int MID_MIN_CYC = (BIT10_CYC * 3 + 3) / 4;
  localparam int EOF_CYC = BIT10_CYC * 3 / 2;
  localparam int RXCLK10_NS = 400;
  localparam int RXCLK10_HALF = RXCLK10_NS / 2 / CLK_NS;
  // ------------------------------------------------------------
  // coding
  // ------------------------------------------------------------
  localparam int SYNC_IDLES = 12;
  localparam int CG_BITS = 5;
  localparam int SYNC_ONES = SYNC_IDLES * CG_BITS;
  localparam int HOLD_IDLES = 16;
  localparam logic [3:0] IDLE_PAIR_ONES = 4'hA;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [3:0] NIB_PRE = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam logic [3:0] NIB_INVALID = 4'h6;
  localparam logic [2:0] PH_LAST = 3'h4;
  localparam logic [2:0] PH_J_ZERO = 3'h2;
  localparam logic [2:0] PH_CLK_HI = 3'h2;
  localparam int TAP_A = 10;
  localparam int TAP_B = 8;
  // ------------------------------------------------------------
  // synchronised pin positions
  // ------------------------------------------------------------
  localparam int PIN_LCLK = 0;
  localparam int PIN_MPOS = 1;
  localparam int PIN_MNEG = 2;
  localparam int PIN_ENERGY = 3;
  localparam int PIN_FLP = 4;
  localparam int PIN_MAN = 5;
  localparam int PIN_SQ = 6;
  localparam int PIN_NLP = 7;
  localparam int PIN_SP100 = 8;
  localparam int PIN_FDX = 9;
  localparam int PIN_BYP = 10;
  localparam int PIN_W = 11;

  typedef enum logic [2:0] {st_idle, st_j, st_k, st_data, st_bad} pcs_state_type;
endpackage

// ---- core/rx_code_map.sv ----
// 5B code-group to 4B nibble lookup
// assumes code bits ordered first received in bit 4
`timescale 1ns/1ps
module rx_code_map (
  input wire logic [4:0] code,
  output logic [3:0] nibble,
  output logic data_ok
);
  // ------------------------------------------------------------
  // data code-groups only; control and invalid codes report not ok
  // ------------------------------------------------------------
  always_comb begin
    data_ok = 1'b1;
    unique case (code)
      5'h1E: nibble = 4'h0;
      5'h09: nibble = 4'h1;
      5'h14: nibble = 4'h2;
      5'h15: nibble = 4'h3;
      5'h0A: nibble = 4'h4;
      5'h0B: nibble = 4'h5;
      5'h0E: nibble = 4'h6;
      5'h0F: nibble = 4'h7;
      5'h12: nibble = 4'h8;
      5'h13: nibble = 4'h9;
      5'h16: nibble = 4'hA;
      5'h17: nibble = 4'hB;
      5'h1A: nibble = 4'hC;
      5'h1B: nibble = 4'hD;
      5'h1C: nibble = 4'hE;
      5'h1D: nibble = 4'hF;
      default: begin
        nibble = 4'h0;
        data_ok = 1'b0;
      end
    endcase
  end
endmodule

// ---- core/phy_rx_path.sv ----
// 10/100 receive path: manchester and mlt-3 decode, descrambler, pcs, mii receive side
// assumes line-side pins asynchronous to clk, tx_active from logic on clk
`timescale 1ns/1ps
module phy_rx_path #(
  parameter int unsigned HOLD_CYCLES = phy_rx_pkg::HOLD_CYC,
  parameter int unsigned LINK_CYCLES = phy_rx_pkg::LINK_CYC,
  parameter int unsigned NLP_CYCLES = phy_rx_pkg::NLP_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic line_clk,
  input wire logic mlt3_pos,
  input wire logic mlt3_neg,
  input wire logic sig_energy,
  input wire logic flp_seen,
  input wire logic manch_in,
  input wire logic squelch_ok,
  input wire logic nlp_pulse,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic descr_bypass,
  input wire logic tx_active,
  output logic rx_clk,
  output logic [3:0] rxd,
  output logic rx_dv,
  output logic rx_er,
  output logic crs,
  output logic col,
  output logic link_up_100,
  output logic link_up_10,
  output logic tx_enable_10,
  output logic descr_locked
);
  import phy_rx_pkg::*;

  default clocking dcb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  logic [PIN_W-1:0] pins, sync1_reg, sync2_reg, prev_reg;
  logic sym_en, sp100, fdx, bypass, man, m_edge, nlp_rise, sq, energy, flp;
  logic [1:0] mlt_now;
  assign pins = {descr_bypass, full_duplex, speed_100, nlp_pulse, squelch_ok, manch_in,
                 flp_seen, sig_energy, mlt3_neg, mlt3_pos, line_clk};
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      prev_reg <= '0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
    end
  end
  assign sym_en = sync2_reg[PIN_LCLK] & ~prev_reg[PIN_LCLK];
  assign sp100 = sync2_reg[PIN_SP100];
  assign fdx = sync2_reg[PIN_FDX];
  assign bypass = sync2_reg[PIN_BYP];
  assign man = sync2_reg[PIN_MAN];
  assign m_edge = sync2_reg[PIN_MAN] ^ prev_reg[PIN_MAN];
  assign nlp_rise = sync2_reg[PIN_NLP] & ~prev_reg[PIN_NLP];
  assign sq = sync2_reg[PIN_SQ];
  assign energy = sync2_reg[PIN_ENERGY];
  assign flp = sync2_reg[PIN_FLP];
  assign mlt_now = {sync2_reg[PIN_MNEG], sync2_reg[PIN_MPOS]};

  // ------------------------------------------------------------
  // mlt-3 decode and descrambler
  // ------------------------------------------------------------
  logic [1:0] mlt_reg, mlt_next;
  logic nrzi_reg, nrzi_next, nrzi_new, nrz, pred, plain, rbit;
  logic [10:0] lfsr_reg, lfsr_next;
  logic lock_reg, lock_next;
  logic [5:0] ones_reg, ones_next;
  logic [2:0] five_reg, five_next;
  logic [4:0] idles_reg, idles_next;
  logic [31:0] hold_reg, hold_next;
  always_comb begin
    nrzi_new = nrzi_reg ^ (mlt_now != mlt_reg);
    nrz = nrzi_new ^ nrzi_reg;
    pred = lfsr_reg[TAP_A] ^ lfsr_reg[TAP_B];
    plain = nrz ^ pred;
    rbit = bypass ? nrz : plain;
    mlt_next = mlt_reg;
    nrzi_next = nrzi_reg;
    lfsr_next = lfsr_reg;
    lock_next = lock_reg;
    ones_next = ones_reg;
    five_next = five_reg;
    idles_next = idles_reg;
    hold_next = lock_reg ? hold_reg + 32'h1 : hold_reg;
    if (sym_en && sp100) begin
      mlt_next = mlt_now;
      nrzi_next = nrzi_new;
      lfsr_next = {lfsr_reg[9:0], lock_reg ? pred : ~nrz};
      ones_next = plain ? ((&ones_reg) ? ones_reg : ones_reg + 6'h1) : 6'h0;
      if (!lock_reg && plain && ones_reg == 6'(SYNC_ONES - 1)) begin
        lock_next = 1'b1;
        hold_next = '0;
        idles_next = '0;
        five_next = '0;
      end
      if (lock_reg) begin
        five_next = (plain && five_reg != 3'(CG_BITS - 1)) ? five_reg + 3'h1 : 3'h0;
        if (plain && five_reg == 3'(CG_BITS - 1)) begin
          idles_next = idles_reg + 5'h1;
          if (idles_reg == 5'(HOLD_IDLES - 1)) begin
            idles_next = '0;
            hold_next = '0;
          end
        end
      end
    end
    if ((lock_reg && hold_reg == HOLD_CYCLES - 1) || !sp100) begin
      lock_next = 1'b0;
      lfsr_next = '0;
      ones_next = '0;
      idles_next = '0;
      five_next = '0;
      hold_next = '0;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mlt_reg <= '0;
      nrzi_reg <= 1'b0;
      lfsr_reg <= '0;
      lock_reg <= 1'b0;
      ones_reg <= '0;
      five_reg <= '0;
      idles_reg <= '0;
      hold_reg <= '0;
    end else begin
      mlt_reg <= mlt_next;
      nrzi_reg <= nrzi_next;
      lfsr_reg <= lfsr_next;
      lock_reg <= lock_next;
      ones_reg <= ones_next;
      five_reg <= five_next;
      idles_reg <= idles_next;
      hold_reg <= hold_next;
    end
  end

  // ------------------------------------------------------------
  // signal detect and link monitor
  // ------------------------------------------------------------
  logic sd, link100_reg, link100_next;
  logic [31:0] link_cnt_reg, link_cnt_next;
  assign sd = energy & ~flp & lock_reg;
  always_comb begin
    link_cnt_next = link_cnt_reg;
    link100_next = link100_reg;
    if (!sd) begin
      link_cnt_next = '0;
      link100_next = 1'b0;
    end else if (link_cnt_reg == LINK_CYCLES - 1) begin
      link100_next = 1'b1;
    end else begin
      link_cnt_next = link_cnt_reg + 32'h1;
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      link_cnt_reg <= '0;
      link100_reg <= 1'b0;
    end else begin
      link_cnt_reg <= link_cnt_next;
      link100_reg <= link100_next;
    end
  end

  // ------------------------------------------------------------
  // code-group alignment and 5b/4b decode
  // ------------------------------------------------------------
  pcs_state_type pst_reg, pst_next;
  logic [9:0] sh_reg, sh_next, sh_new;
  logic [2:0] phase_reg, phase_next;
  logic [3:0] run_reg, run_next, pnib_reg, pnib_next, map_nib;
  logic idl_reg, idl_next, pdv_reg, pdv_next, per_reg, per_next, map_ok;
  logic [4:0] code;
  assign sh_new = {sh_reg[8:0], rbit};
  assign code = sh_new[4:0];
  rx_code_map u_map (
    .code(code),
    .nibble(map_nib),
    .data_ok(map_ok)
  );
  always_comb begin
    pst_next = pst_reg;
    sh_next = sh_reg;
    phase_next = phase_reg;
    run_next = run_reg;
    idl_next = idl_reg;
    pnib_next = pnib_reg;
    pdv_next = pdv_reg;
    per_next = per_reg;
    if (!link100_reg) begin
      pst_next = st_idle;
      pdv_next = 1'b0;
      per_next = 1'b0;
      run_next = '0;
    end else if (sym_en) begin
      sh_next = sh_new;
      run_next = rbit ? ((&run_reg) ? run_reg : run_reg + 4'h1) : 4'h0;
      phase_next = (phase_reg == PH_LAST) ? 3'h0 : phase_reg + 3'h1;
      unique case (pst_reg)
        st_idle: begin
          if (!rbit && run_reg >= IDLE_PAIR_ONES) begin
            pst_next = st_j;
            phase_next = PH_J_ZERO + 3'h1;
          end
        end
        st_j, st_k: begin
          if (phase_reg == PH_LAST) begin
            idl_next = 1'b0;
            if (code == ((pst_reg == st_j) ? CG_J : CG_K)) begin
              pnib_next = NIB_PRE;
              pdv_next = 1'b1;
              per_next = 1'b0;
              pst_next = (pst_reg == st_j) ? st_k : st_data;
            end else begin
              pnib_next = NIB_BAD_SSD;
              pdv_next = 1'b0;
              per_next = 1'b1;
              pst_next = st_bad;
            end
          end
        end
        st_data: begin
          if (phase_reg == PH_LAST) begin
            idl_next = (code == CG_IDLE);
            if (code == CG_T || (code == CG_IDLE && idl_reg)) begin
              pst_next = st_idle;
              pdv_next = 1'b0;
              per_next = 1'b0;
            end else begin
              pdv_next = 1'b1;
              per_next = !map_ok;
              pnib_next = map_ok ? map_nib : NIB_INVALID;
            end
          end
        end
        st_bad: begin
          if (phase_reg == PH_LAST) begin
            idl_next = (code == CG_IDLE);
            pnib_next = NIB_BAD_SSD;
            per_next = 1'b1;
            if (code == CG_IDLE && idl_reg) begin
              pst_next = st_idle;
              per_next = 1'b0;
            end
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pst_reg <= st_idle;
      sh_reg <= '0;
      phase_reg <= '0;
      run_reg <= '0;
      idl_reg <= 1'b0;
      pnib_reg <= '0;
      pdv_reg <= 1'b0;
      per_reg <= 1'b0;
    end else begin
      pst_reg <= pst_next;
      sh_reg <= sh_next;
      phase_reg <= phase_next;
      run_reg <= run_next;
      idl_reg <= idl_next;
      pnib_reg <= pnib_next;
      pdv_reg <= pdv_next;
      per_reg <= per_next;
    end
  end

  // ------------------------------------------------------------
  // 10m manchester decode, link pulses, heartbeat
  // ------------------------------------------------------------
  logic crs10_reg, crs10_next, nrdy_reg, nrdy_next, clk10_reg, clk10_next, dv10_reg, dv10_next;
  logic link10_reg, link10_next, tx_prev_reg, rx10_en, fall10;
  logic [5:0] since_reg, since_next;
  logic [3:0] nib10_reg, nib10_next, nout_reg, nout_next, rxd10_reg, rxd10_next;
  logic [1:0] bcnt_reg, bcnt_next;
  logic [6:0] div_reg, div_next;
  logic [31:0] nlp_cnt_reg, nlp_cnt_next;
  logic [7:0] hb_reg, hb_next;
  always_comb begin
    crs10_next = crs10_reg;
    nib10_next = nib10_reg;
    nout_next = nout_reg;
    rxd10_next = rxd10_reg;
    bcnt_next = bcnt_reg;
    nrdy_next = nrdy_reg;
    dv10_next = dv10_reg;
    clk10_next = clk10_reg;
    since_next = (since_reg == 6'(EOF_CYC)) ? since_reg : since_reg + 6'h1;
    fall10 = (div_reg == 7'(RXCLK10_HALF - 1)) && clk10_reg;
    div_next = div_reg + 7'h1;
    if (div_reg == 7'(RXCLK10_HALF - 1)) begin
      div_next = '0;
      clk10_next = ~clk10_reg;
    end
    if (fall10) begin
      dv10_next = nrdy_reg;
      rxd10_next = nout_reg;
      nrdy_next = 1'b0;
    end
    rx10_en = !sp100 && sq && link10_reg;
    if (!rx10_en) begin
      crs10_next = 1'b0;
    end else if (m_edge && !crs10_reg) begin
      crs10_next = 1'b1;
      since_next = '0;
      bcnt_next = '0;
    end else if (crs10_reg && m_edge && since_reg >= 6'(MID_MIN_CYC)) begin
      since_next = '0;
      nib10_next = {man, nib10_reg[3:1]};
      bcnt_next = bcnt_reg + 2'h1;
      if (&bcnt_reg) begin
        nrdy_next = 1'b1;
        nout_next = {man, nib10_reg[3:1]};
      end
    end else if (crs10_reg && since_reg >= 6'(EOF_CYC - 1)) begin
      crs10_next = 1'b0;
    end
    nlp_cnt_next = nlp_cnt_reg + 32'h1;
    link10_next = link10_reg;
    if (nlp_rise) begin
      nlp_cnt_next = '0;
      link10_next = 1'b1;
    end else if (nlp_cnt_reg >= NLP_CYCLES - 1) begin
      nlp_cnt_next = nlp_cnt_reg;
      link10_next = 1'b0;
    end
    hb_next = (hb_reg != 8'h0) ? hb_reg - 8'h1 : hb_reg;
    if (tx_prev_reg && !tx_active && !sp100 && link10_reg) begin
      hb_next = 8'(HB_CYC);
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      crs10_reg <= 1'b0;
      since_reg <= '0;
      nib10_reg <= '0;
      nout_reg <= '0;
      rxd10_reg <= '0;
      bcnt_reg <= '0;
      nrdy_reg <= 1'b0;
      dv10_reg <= 1'b0;
      div_reg <= '0;
      clk10_reg <= 1'b0;
      nlp_cnt_reg <= '0;
      link10_reg <= 1'b0;
      hb_reg <= '0;
      tx_prev_reg <= 1'b0;
    end else begin
      crs10_reg <= crs10_next;
      since_reg <= since_next;
      nib10_reg <= nib10_next;
      nout_reg <= nout_next;
      rxd10_reg <= rxd10_next;
      bcnt_reg <= bcnt_next;
      nrdy_reg <= nrdy_next;
      dv10_reg <= dv10_next;
      div_reg <= div_next;
      clk10_reg <= clk10_next;
      nlp_cnt_reg <= nlp_cnt_next;
      link10_reg <= link10_next;
      hb_reg <= hb_next;
      tx_prev_reg <= tx_active;
    end
  end

  // ------------------------------------------------------------
  // mii outputs
  // ------------------------------------------------------------
  logic rx_act, tx_ok;
  logic rx_clk_reg, rx_dv_reg, rx_er_reg, crs_reg, col_reg, rx_clk_next, rx_dv_next, rx_er_next;
  logic crs_next, col_next;
  logic [3:0] rxd_reg, rxd_next;
  always_comb begin
    rx_act = sp100 ? (pst_reg != st_idle) : crs10_reg;
    tx_ok = sp100 ? link100_reg : link10_reg;
    col_next = (!fdx && rx_act && tx_active && tx_ok) || (hb_reg != 8'h0);
    crs_next = rx_act || (tx_active && !fdx);
    rx_clk_next = sp100 ? (phase_reg >= PH_CLK_HI) : clk10_reg;
    rxd_next = sp100 ? pnib_reg : rxd10_reg;
    rx_dv_next = sp100 ? pdv_reg : dv10_reg;
    rx_er_next = sp100 && per_reg;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_clk_reg <= 1'b0;
      rxd_reg <= '0;
      rx_dv_reg <= 1'b0;
      rx_er_reg <= 1'b0;
      crs_reg <= 1'b0;
      col_reg <= 1'b0;
    end else begin
      rx_clk_reg <= rx_clk_next;
      rxd_reg <= rxd_next;
      rx_dv_reg <= rx_dv_next;
      rx_er_reg <= rx_er_next;
      crs_reg <= crs_next;
      col_reg <= col_next;
    end
  end
  assign rx_clk = rx_clk_reg;
  assign rxd = rxd_reg;
  assign rx_dv = rx_dv_reg;
  assign rx_er = rx_er_reg;
  assign crs = crs_reg;
  assign col = col_reg;
  assign link_up_100 = link100_reg;
  assign link_up_10 = link10_reg;
  assign tx_enable_10 = link10_reg;
  assign descr_locked = lock_reg;

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_crs_first_edge: assert property ((rx10_en && m_edge && !crs10_reg) |=> crs10_reg)
    else $error("carrier not raised on first edge");
  a_crs_eof_drop: assert property ((crs10_reg && !m_edge && since_reg == 6'(EOF_CYC - 1)) |=> !crs10_reg)
    else $error("carrier not dropped after missing mid-bit edges");
  a_rxclk_toggle: assert property ((div_reg == 7'(RXCLK10_HALF - 1)) |=> (clk10_reg != $past(clk10_reg)))
    else $error("10M receive clock stopped");
  a_desc_lock: assert property ((!lock_reg && sp100 && sym_en && plain && ones_reg == 6'(SYNC_ONES - 1))
    |=> lock_reg)
    else $error("descrambler failed to lock after idles");
  a_hold_expire: assert property ((lock_reg && hold_reg == HOLD_CYCLES - 1) |=> (!lock_reg && lfsr_reg == '0))
    else $error("hold timer expiry kept lock");
  a_link_wait: assert property ($rose(link100_reg) |-> $past(link_cnt_reg) == LINK_CYCLES - 1)
    else $error("link raised before signal detect time");
  a_flp_block: assert property (flp |=> (!link100_reg && link_cnt_reg == '0))
    else $error("fast link pulses counted as signal detect");
  a_bad_ssd: assert property ((link100_reg && sym_en && pst_reg == st_bad && phase_reg == PH_LAST
    && !(code == CG_IDLE && idl_reg)) |=> (per_reg && pnib_reg == NIB_BAD_SSD))
    else $error("bad start not reported as error 1110");
  a_crs_half: assert property ((tx_active && !fdx) |=> crs_reg)
    else $error("carrier missing during half duplex transmit");
  a_crs_full: assert property ((fdx && !rx_act) |=> !crs_reg)
    else $error("carrier raised by transmit in full duplex");
  a_heartbeat: assert property ((tx_prev_reg && !tx_active && !sp100 && link10_reg) |-> ##2 col_reg [*8])
    else $error("heartbeat pulse missing after transmit");
endmodule

// ---- sim/mac_rx_model.sv ----
// mac receive side: logs the first 16 nibble periods that carry data or error
// assumes rxd, rx_dv and rx_er settle before the rising edge of rx_clk
`timescale 1ns/1ps
module mac_rx_model (
  input wire logic rx_clk,
  input wire logic [3:0] rxd,
  input wire logic rx_dv,
  input wire logic rx_er
);
  logic [5:0] rec [0:15];
  int cnt = 0;
  always @(posedge rx_clk) begin
    if ((rx_dv | rx_er) === 1'b1 && cnt < 16) begin
      rec[cnt] <= {rx_er, rx_dv, rxd};
      cnt <= cnt + 1;
    end
  end
endmodule

// ---- sim/testbench.sv ----
// self-checking bench: scrambled mlt-3 line stimulus, mii receive checks, 10M status
// assumes phy_rx_path with shortened hold, link and pulse-loss counts
`timescale 1ns/1ps
module testbench;
  import phy_rx_pkg::*;
  logic clk = 0, reset_n = 0, line_clk = 0, mlt3_pos = 0, mlt3_neg = 0;
  logic sig_energy = 1, flp_seen = 1, nlp_pulse = 0, speed_100 = 1, full_duplex = 0, tx_active = 0;
  logic manch_in = 0, squelch_ok = 0;
  logic rx_clk, rx_dv, rx_er, crs, col, link_up_100, link_up_10, tx_enable_10, descr_locked;
  logic [3:0] rxd;
  logic [10:0] scr = 11'h7FF;
  logic [1:0] lvl = 2'h0;
  int err_total = 0, num_checks = 0;
  phy_rx_path #(.HOLD_CYCLES(4000), .LINK_CYCLES(200), .NLP_CYCLES(2000)) uut (.clk(clk), .reset_n(reset_n),
    .line_clk(line_clk), .mlt3_pos(mlt3_pos), .mlt3_neg(mlt3_neg), .sig_energy(sig_energy), .flp_seen(flp_seen),
    .manch_in(manch_in), .squelch_ok(squelch_ok), .nlp_pulse(nlp_pulse), .speed_100(speed_100),
    .full_duplex(full_duplex),
    .descr_bypass(1'b0), .tx_active(tx_active), .rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er),
    .crs(crs), .col(col), .link_up_100(link_up_100), .link_up_10(link_up_10), .tx_enable_10(tx_enable_10),
    .descr_locked(descr_locked));
  mac_rx_model mac (.rx_clk(rx_clk), .rxd(rxd), .rx_dv(rx_dv), .rx_er(rx_er));
  initial begin
    forever #2 clk = ~clk;
  end
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [5:0] exp, input logic [5:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // one symbol: scramble, step the mlt-3 level on a one, take on line_clk rising
  task automatic sym(input logic b);
    logic n;
    n = scr[10] ^ scr[8];
    scr = {scr[9:0], n};
    if (b ^ n) lvl = lvl + 2'h1;
    mlt3_pos = (lvl == 2'h1);
    mlt3_neg = (lvl == 2'h3);
    line_clk = 0;
    tick(8);
    line_clk = 1;
    tick(8);
  endtask
  // one manchester bit of 25 clocks: the level after the mid-bit edge is the bit
  task automatic man_bit(input logic b);
    manch_in = ~b;
    tick(12);
    manch_in = b;
    tick(13);
  endtask
  task automatic cg(input logic [4:0] c);
    for (int i = 4; i >= 0; i--) sym(c[i]);
  endtask
  task automatic idles(input int n);
    repeat (n) cg(CG_IDLE);
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_link100;
    idles(40);
    chk("locked", 1, descr_locked);
    chk("link flp", 0, link_up_100);
    flp_seen = 0;
    idles(2);
    chk("link early", 0, link_up_100);
    idles(24);
    chk("link up", 1, link_up_100);
  endtask
  task automatic t_packet;
    logic [5:0] exp [0:4] = '{6'h15, 6'h15, 6'h1A, 6'h13, 6'h1F};
    int b = mac.cnt;
    cg(CG_J); cg(CG_K); cg(5'h16); cg(5'h15); cg(5'h1D); cg(CG_T); cg(5'h07); idles(4);
    chk("pkt count", 5, 6'(mac.cnt - b));
    for (int i = 0; i < 5; i++) chk("pkt nibble", exp[i], mac.rec[b + i]);
    chk("crs end", 0, crs);
  endtask
  task automatic t_invalid;
    int b = mac.cnt;
    cg(CG_J); cg(CG_K); cg(5'h00); cg(CG_T); cg(5'h07); idles(4);
    chk("bad er", 1, mac.rec[b + 2][5]);
    chk("bad nib", NIB_INVALID, mac.rec[b + 2][3:0]);
  endtask
  task automatic t_bad_ssd;
    int b = mac.cnt;
    cg(5'h1C); cg(5'h1C); idles(4);
    chk("ssd count", 3, 6'(mac.cnt - b));
    chk("ssd rec", {2'b10, NIB_BAD_SSD}, mac.rec[b + 1]);
    chk("ssd release", 0, {crs, rx_er});
    chk("still locked", 1, descr_locked);
    tick(4100);
    chk("hold lost", 0, descr_locked);
  endtask
  task automatic t_10m;
    int b = mac.cnt;
    speed_100 = 0;
    tick(5);
    nlp_pulse = 1;
    tick(2);
    nlp_pulse = 0;
    tick(5);
    chk("link10", 1, {link_up_10, tx_enable_10} == 2'b11);
    squelch_ok = 1;
    tick(3);
    man_bit(1);
    chk("crs 10m", 1, crs);
    for (int i = 0; i < 4; i++) man_bit(i != 2);
    tx_active = 1;
    tick(2);
    chk("col 10m", 1, col);
    tick(28);
    chk("rx 10m end", 0, col);
    chk("crs hdx", 1, crs);
    full_duplex = 1;
    tick(4);
    chk("crs fdx", 0, crs);
    tx_active = 0;
    tick(10);
    chk("heartbeat on", 1, col);
    tick(250);
    chk("heartbeat off", 0, col);
    chk("10m count", 1, 6'(mac.cnt - b));
    chk("10m nibble", 6'h1B, mac.rec[b]);
    tick(2100);
    chk("link10 lost", 0, link_up_10);
  endtask
  initial begin
    tick(3);
    reset_n = 1;
    tick(2);
    t_link100;
    t_packet;
    t_invalid;
    t_bad_ssd;
    t_10m;
    give_verdict;
  end
  initial begin
    #200000;
    err_total++;
    give_verdict;
  end
endmodule
